// >>> pkg/bdmd_pkg.sv
package bdmd_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int BANK_W = 3;
   localparam int NUM_BANKS = 7;
   // special register offsets
   localparam logic [7:0] INDIRECT_PORT_ZERO = 8'h00;
   localparam logic [7:0] POINTER_ZERO = 8'h01;
   localparam logic [7:0] INDIRECT_PORT_ONE = 8'h02;
   localparam logic [7:0] POINTER_ONE = 8'h03;
   localparam logic [7:0] BANK_SELECT = 8'h04;
   // area boundaries
   localparam logic [7:0] SPECIAL_LAST = 8'h3F;
   localparam logic [7:0] SPECIAL_IMPL_LAST = 8'h3D;
   localparam logic [7:0] GENERAL_FIRST = 8'h40;
   localparam logic [7:0] GENERAL_LAST = 8'hFF;
   localparam logic [7:0] DISPLAY_LAST_SMALL = 8'h70;
   localparam logic [7:0] DISPLAY_LAST_LARGE = 8'h9F;
   localparam logic [7:0] DISPLAY_BANK = 8'h01;
   localparam logic [7:0] RESET_BANK = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int DISPLAY_DEPTH = 96;
   localparam int GENERAL_DEPTH = 192;

   typedef enum logic [1:0] {
      BDMD_OP_WRITE,
      BDMD_OP_BIT_SET,
      BDMD_OP_BIT_CLR
   } bdmd_op_t;

   // one core write request
   typedef struct packed {
      logic valid;
      bdmd_op_t op;
      logic [7:0] addr;
      logic [7:0] data;
      logic [2:0] bit_sel;
   } bdmd_wr_t;
endpackage : bdmd_pkg

// >>> core/bdmd_data_memory.sv
`timescale 1ns/1ps
module bdmd_data_memory #(
   parameter bit LARGE_DISPLAY = 1'b1,
   parameter int NUM_BANKS = bdmd_pkg::NUM_BANKS
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic wdt_sleep_reset_in,
   input wire bdmd_pkg::bdmd_wr_t wr_in,
   input wire logic [7:0] rd_addr_in,
   input wire logic [7:0] sfr_rdata_in,
   input wire logic [63:0] sfr_readonly_in,
   output logic [7:0] rd_data_out,
   output logic sfr_wr_out,
   output logic [7:0] sfr_addr_out,
   output logic [7:0] sfr_wdata_out,
   output logic [7:0] bank_select_out,
   output logic [767:0] segment_data_out
);
   localparam logic [7:0] DISP_LAST = LARGE_DISPLAY ?
      bdmd_pkg::DISPLAY_LAST_LARGE : bdmd_pkg::DISPLAY_LAST_SMALL;
   localparam int GEN_DEPTH = NUM_BANKS * bdmd_pkg::GENERAL_DEPTH;
   // holes inside the special map hold nothing on either variant
   localparam logic [63:0] SFR_HOLES = 64'h0000_0000_8000_1000;

   logic [7:0] gen_mem [GEN_DEPTH];
   logic [7:0] disp_mem [bdmd_pkg::DISPLAY_DEPTH];
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic [7:0] bank_select;
   logic [7:0] rd_data;

   // resolved target of one access
   typedef struct packed {
      logic sfr;
      logic gen;
      logic disp;
      logic null_hit;
      logic [7:0] addr;
      logic [2:0] bank;
   } bdmd_tgt_t;

   // indirect port substitutes pointer; picks the bank
   function automatic bdmd_tgt_t resolve(input logic [7:0] a,
                                         input logic [7:0] p0,
                                         input logic [7:0] p1,
                                         input logic [7:0] bs);
      bdmd_tgt_t t;
      logic [7:0] ea;
      logic [7:0] bk;
      logic ind;
      t = '0;
      ind = 1'b0;
      ea = a;
      bk = 8'h00;
      if (a == bdmd_pkg::INDIRECT_PORT_ZERO) begin
         ind = 1'b1;
         ea = p0;
      end else if (a == bdmd_pkg::INDIRECT_PORT_ONE) begin
         ind = 1'b1;
         ea = p1;
         bk = bs;
      end
      t.addr = ea;
      t.bank = bk[2:0];
      // pointer aimed at an indirect port
      if (ind && (ea == bdmd_pkg::INDIRECT_PORT_ZERO ||
                  ea == bdmd_pkg::INDIRECT_PORT_ONE)) begin
         t.null_hit = 1'b1;
      // common special area, for bank 1 too
      end else if (ea <= bdmd_pkg::SPECIAL_LAST) begin
         t.sfr = 1'b1;
      // display bank; above last location is null
      end else if (bk == bdmd_pkg::DISPLAY_BANK) begin
         t.disp = (ea <= DISP_LAST);
         t.null_hit = !(ea <= DISP_LAST);
      // general banks within the implemented count
      end else if (bk < 8'(NUM_BANKS)) begin
         t.gen = 1'b1;
      end else begin
         t.null_hit = 1'b1;
      end
      return t;
   endfunction : resolve

   // bank joined with pointer, rebased to storage index
   function automatic int gen_index(input bdmd_tgt_t t);
      return int'(t.bank) * bdmd_pkg::GENERAL_DEPTH +
         int'(t.addr - bdmd_pkg::GENERAL_FIRST);
   endfunction : gen_index

   // write, bit set or bit clear on one byte
   function automatic logic [7:0] modify(input logic [7:0] old,
                                         input bdmd_pkg::bdmd_wr_t w);
      logic [7:0] m;
      m = 8'h01 << w.bit_sel;
      unique case (w.op)
         bdmd_pkg::BDMD_OP_BIT_SET: return old | m;
         bdmd_pkg::BDMD_OP_BIT_CLR: return old & ~m;
         default: return w.data;
      endcase
   endfunction : modify

   // reserved tail and holes of the special map read as zero
   function automatic logic sfr_empty(input logic [7:0] a);
      return (a > bdmd_pkg::SPECIAL_IMPL_LAST) || SFR_HOLES[a[5:0]];
   endfunction : sfr_empty

   wire bdmd_tgt_t rd_tgt = resolve(rd_addr_in, pointer_zero,
                                     pointer_one, bank_select);
   wire bdmd_tgt_t wr_tgt = resolve(wr_in.addr, pointer_zero,
                                     pointer_one, bank_select);
   // storage indices, only read when the matching hit flag is set
   wire integer rd_gidx = gen_index(rd_tgt);
   wire integer wr_gidx = gen_index(wr_tgt);
   wire integer rd_didx = int'(rd_tgt.addr - bdmd_pkg::GENERAL_FIRST);
   wire integer wr_didx = int'(wr_tgt.addr - bdmd_pkg::GENERAL_FIRST);

   // locally held special registers, read back through the same decode
   wire logic rd_local = rd_tgt.sfr &&
      (rd_tgt.addr == bdmd_pkg::POINTER_ZERO ||
       rd_tgt.addr == bdmd_pkg::POINTER_ONE ||
       rd_tgt.addr == bdmd_pkg::BANK_SELECT);
   wire logic [7:0] local_val =
      (rd_tgt.addr == bdmd_pkg::POINTER_ZERO) ? pointer_zero :
      (rd_tgt.addr == bdmd_pkg::POINTER_ONE) ? pointer_one : bank_select;

   wire logic rd_reserved = rd_tgt.sfr && sfr_empty(rd_tgt.addr);

   wire logic wr_sfr_ok = wr_in.valid && wr_tgt.sfr &&
      !sfr_readonly_in[wr_tgt.addr[5:0]] && !sfr_empty(wr_tgt.addr);

   // the peripheral owner holds the byte, so bit ops merge its read value
   wire logic [7:0] sfr_merge = modify(sfr_rdata_in, wr_in);

   // read mux; give zero via null_hit
   always_comb begin
      rd_data = bdmd_pkg::ZERO_BYTE;
      if (rd_tgt.null_hit || rd_reserved) begin
         rd_data = bdmd_pkg::ZERO_BYTE;
      end else if (rd_local) begin
         rd_data = local_val;
      end else if (rd_tgt.sfr) begin
         rd_data = sfr_rdata_in;
      end else if (rd_tgt.disp) begin
         rd_data = disp_mem[rd_didx];
      end else if (rd_tgt.gen) begin
         rd_data = gen_mem[rd_gidx];
      end
   end

   // write strobes for the locally held special registers
   wire logic wr_ptr0 = wr_sfr_ok &&
      (wr_tgt.addr == bdmd_pkg::POINTER_ZERO);
   wire logic wr_ptr1 = wr_sfr_ok &&
      (wr_tgt.addr == bdmd_pkg::POINTER_ONE);
   wire logic wr_bank = wr_sfr_ok &&
      (wr_tgt.addr == bdmd_pkg::BANK_SELECT);
   // everything above the bank selector belongs to the peripheral owner
   wire logic wr_periph = wr_sfr_ok &&
      (wr_tgt.addr > bdmd_pkg::BANK_SELECT);
   wire logic wr_gen = wr_in.valid && wr_tgt.gen;
   wire logic wr_disp = wr_in.valid && wr_tgt.disp;

   // next values; bit set and clear work on the held byte
   wire logic [7:0] next_pointer_zero =
      wr_ptr0 ? modify(pointer_zero, wr_in) : pointer_zero;
   wire logic [7:0] next_pointer_one =
      wr_ptr1 ? modify(pointer_one, wr_in) : pointer_one;
   // the written value is the bank number itself
   wire logic [7:0] next_bank_select =
      wr_bank ? modify(bank_select, wr_in) : bank_select;
   // a watchdog reset in power-down leaves the bank alone
   wire logic bank_clear = sys_rst_in && !wdt_sleep_reset_in;

   // first pointer, always aimed into bank 0
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pointer_zero <= bdmd_pkg::ZERO_BYTE;
      end else begin
         pointer_zero <= next_pointer_zero;
      end
   end

   // second pointer, aimed into the selected bank
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pointer_one <= bdmd_pkg::ZERO_BYTE;
      end else begin
         pointer_one <= next_pointer_one;
      end
   end

   // bank selector, held through a sleep watchdog reset
   always_ff @(posedge sys_clk_in) begin
      if (bank_clear) begin
         bank_select <= bdmd_pkg::RESET_BANK;
      end else if (!sys_rst_in) begin
         bank_select <= next_bank_select;
      end
   end

   // general storage; contents are undefined after reset like real RAM
   always_ff @(posedge sys_clk_in) begin
      if (wr_gen) begin
         gen_mem[wr_gidx] <= modify(gen_mem[wr_gidx], wr_in);
      end
   end

   // display reached only through the second pair with bank 1
   always_ff @(posedge sys_clk_in) begin
      if (wr_disp) begin
         disp_mem[wr_didx] <= modify(disp_mem[wr_didx], wr_in);
      end
   end

   // registered read data, one cycle behind the address
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= bdmd_pkg::ZERO_BYTE;
      end else begin
         rd_data_out <= rd_data;
      end
   end

   // write strobe for special addresses passed to the peripheral owner
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         sfr_wr_out <= 1'b0;
      end else begin
         sfr_wr_out <= wr_periph;
      end
   end

   // address and merged byte travel beside the strobe
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         sfr_addr_out <= bdmd_pkg::ZERO_BYTE;
         sfr_wdata_out <= bdmd_pkg::ZERO_BYTE;
      end else begin
         sfr_addr_out <= wr_tgt.addr;
         sfr_wdata_out <= sfr_merge;
      end
   end

   assign bank_select_out = bank_select;

   // segment data follows display storage with no transfer step
   always_ff @(posedge sys_clk_in) begin
      for (int i = 0; i < bdmd_pkg::DISPLAY_DEPTH; i++) begin
         segment_data_out[i*8 +: 8] <= disp_mem[i];
      end
   end
endmodule : bdmd_data_memory

// >>> sim/bdmd_checker_assertions.sv
`timescale 1ns/1ps
module bdmd_checker (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic wdt_sleep_reset_in,
   input wire bdmd_pkg::bdmd_wr_t wr_in,
   input wire logic [7:0] rd_addr_in,
   input wire logic [63:0] sfr_readonly_in,
   input wire logic [7:0] rd_data_out,
   input wire logic sfr_wr_out,
   input wire logic [7:0] sfr_addr_out,
   input wire logic [7:0] sfr_wdata_out,
   input wire logic [7:0] bank_select_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   // plain byte writes, which load their whole data byte into the selector
   wire logic is_wr = wr_in.valid && wr_in.op == bdmd_pkg::BDMD_OP_WRITE;
   bank_rst_a: assert property ($fell(sys_rst_in) &&
      !$past(wdt_sleep_reset_in) |-> bank_select_out == 8'h00)
      else $error("bank not cleared by reset");
   bank_keep_a: assert property ($fell(sys_rst_in) &&
      $past(wdt_sleep_reset_in) |-> bank_select_out ==
      $past(bank_select_out, 3)) else $error("bank lost on sleep reset");
   bank_write_a: assert property (is_wr && wr_in.addr == 8'h04
      |=> bank_select_out == $past(wr_in.data))
      else $error("bank selector not loaded");
   bank_hold_a: assert property (!(wr_in.valid &&
      wr_in.addr inside {8'h00, 8'h02, 8'h04}) |=> $stable(bank_select_out))
      else $error("bank selector moved");
   sfr_pass_a: assert property (is_wr && wr_in.addr inside
      {[8'h05:8'h0B]} && !sfr_readonly_in[wr_in.addr[5:0]] |=> sfr_wr_out &&
      sfr_addr_out == $past(wr_in.addr) && sfr_wdata_out == $past(wr_in.data))
      else $error("special write not passed on");
   sfr_range_a: assert property (sfr_wr_out |-> $past(wr_in.valid) &&
      sfr_addr_out inside {[8'h05:8'h3D]} &&
      !(sfr_addr_out inside {8'h0C, 8'h1F}) &&
      !sfr_readonly_in[sfr_addr_out[5:0]])
      else $error("special write where none allowed");
   rd_resv_a: assert property (rd_addr_in inside {8'h3E, 8'h3F}
      |=> rd_data_out == 8'h00) else $error("reserved read not zero");
   rd_back_a: assert property (is_wr && wr_in.addr >= 8'h40 ##1
      (!wr_in.valid && rd_addr_in == $past(wr_in.addr))
      |=> rd_data_out == $past(wr_in.data, 2)) else $error("readback wrong");
endmodule : bdmd_checker
bind bdmd_data_memory bdmd_checker u_chk (.sys_clk_in, .sys_rst_in,
   .wdt_sleep_reset_in, .wr_in, .rd_addr_in, .sfr_readonly_in, .rd_data_out,
   .sfr_wr_out, .sfr_addr_out, .sfr_wdata_out, .bank_select_out);

// >>> sim/bdmd_sfr_model.sv
`timescale 1ns/1ps
module bdmd_sfr_model (
   input wire logic sys_clk_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic [7:0] last_addr_out,
   output logic [7:0] last_data_out
);
   // zero only for address FFH, so a zero read of a special address cannot come from here
   assign sfr_rdata_out = ~sfr_addr_in;
   always_ff @(posedge sys_clk_in) begin
      if (sfr_wr_in) begin
         last_addr_out <= sfr_addr_in;
         last_data_out <= sfr_wdata_in;
      end
   end
endmodule : bdmd_sfr_model

// >>> sim/tb_banked_data_memory_decode.sv
`timescale 1ns/1ps
module tb_banked_data_memory_decode;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic wdt = 1'b0;
   bdmd_pkg::bdmd_wr_t wr = '0;
   logic [7:0] ra = 8'h40;
   logic [7:0] rdat, srd, sad, swd, bank, l_a, l_d;
   logic swr;
   logic [767:0] seg;
   int n_mismatch = 0;
   int checks_done = 0;
   // system clock
   initial forever #50 sys_clk_in = ~sys_clk_in;
   // address 08H is marked read-only
   bdmd_data_memory u_dut (.sys_clk_in, .sys_rst_in,
      .wdt_sleep_reset_in(wdt), .wr_in(wr), .rd_addr_in(ra),
      .sfr_rdata_in(srd), .sfr_readonly_in(64'h0000_0000_0000_0100),
      .rd_data_out(rdat), .sfr_wr_out(swr), .sfr_addr_out(sad),
      .sfr_wdata_out(swd), .bank_select_out(bank), .segment_data_out(seg));
   bdmd_sfr_model u_sfr (.sys_clk_in, .sfr_wr_in(swr), .sfr_addr_in(sad),
      .sfr_wdata_in(swd), .sfr_rdata_out(srd), .last_addr_out(l_a),
      .last_data_out(l_d));
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one idle cycle after each write keeps valid a clean pulse
   task automatic op(input bdmd_pkg::bdmd_op_t o, input logic [7:0] a,
      input logic [7:0] d, input logic [2:0] b);
      wr = '{1'b1, o, a, d, b};
      tick();
      wr.valid = 1'b0;
      tick();
   endtask : op
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      op(bdmd_pkg::BDMD_OP_WRITE, a, d, 3'h0);
   endtask : w
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      ra = a;
      tick();
      chk(rdat, exp);
   endtask : rd
   task automatic rst2(input logic keep);
      wdt = keep;
      sys_rst_in = 1'b1;
      tick(2);
      sys_rst_in = 1'b0;
      tick();
   endtask : rst2
   task automatic t_bank;
      w(8'h04, 8'h03);
      chk(bank, 8'h03);
      rst2(1'b1);
      chk(bank, 8'h03);
      rst2(1'b0);
      chk(bank, 8'h00);
      $display("t_bank done");
   endtask : t_bank
   task automatic t_direct;
      w(8'h04, 8'h02);
      w(8'h45, 8'h11);
      w(8'h50, 8'h0F);
      op(bdmd_pkg::BDMD_OP_BIT_SET, 8'h50, 8'h00, 3'h7);
      rd(8'h50, 8'h8F);
      op(bdmd_pkg::BDMD_OP_BIT_CLR, 8'h50, 8'hFF, 3'h0);
      rd(8'h50, 8'h8E);
      w(8'h50, 8'h24);
      rd(8'h50, 8'h24);
      w(8'hFF, 8'hC3);
      rd(8'hFF, 8'hC3);
      $display("t_direct done");
   endtask : t_direct
   task automatic t_indirect;
      w(8'h03, 8'h45);
      w(8'h02, 8'h5A);
      rd(8'h02, 8'h5A);
      rd(8'h45, 8'h11);
      w(8'h04, 8'h03);
      w(8'h02, 8'hA5);
      rd(8'h02, 8'hA5);
      w(8'h04, 8'h02);
      rd(8'h02, 8'h5A);
      w(8'h01, 8'h45);
      rd(8'h00, 8'h11);
      w(8'h03, 8'h02);
      rd(8'h02, 8'h00);
      w(8'h02, 8'h99);
      rd(8'h03, 8'h02);
      $display("t_indirect done");
   endtask : t_indirect
   task automatic t_display;
      // bank one set before display access
      w(8'h04, 8'h01);
      w(8'h03, 8'h9F);
      w(8'h02, 8'h77);
      chk(seg[760 +: 8], 8'h77);
      rd(8'h02, 8'h77);
      w(8'h03, 8'hA0);
      rd(8'h02, 8'h00);
      w(8'h03, 8'h04);
      rd(8'h02, 8'h01);
      w(8'h01, 8'h9F);
      w(8'h00, 8'h33);
      chk(seg[760 +: 8], 8'h77);
      w(8'h04, 8'h00);
      $display("t_display done");
   endtask : t_display
   task automatic t_sfr;
      w(8'h09, 8'h3C);
      chk(l_a, 8'h09);
      chk(l_d, 8'h3C);
      w(8'h08, 8'h55);
      chk(l_a, 8'h09);
      w(8'h3E, 8'h66);
      chk(l_d, 8'h3C);
      w(8'h1F, 8'h5A);
      chk(l_a, 8'h09);
      rd(8'h0C, 8'h00);
      rd(8'h3E, 8'h00);
      rd(8'h3F, 8'h00);
      $display("t_sfr done");
   endtask : t_sfr
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // hang guard
   initial begin
      repeat (3000) @(posedge sys_clk_in);
      n_mismatch++;
      end_sim();
   end
   initial begin
      tick(6);
      sys_rst_in = 1'b0;
      t_bank();
      t_direct();
      t_indirect();
      t_display();
      t_sfr();
      end_sim();
   end
endmodule : tb_banked_data_memory_decode
